//--- src/rrc_reset_remap.sv
// rrc_reset_remap: reset cause record, retention config, low-memory mirror, boot
// sequencing and memory access cost, behind an AXI4-Lite slave.
// assumes rst_b is the power-on reset, synchronous to clock; pins arrive unsynchronised.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module rrc_reset_remap #(
   parameter logic [31:0] MIRROR_LAST_ADDR = 32'h0000_0020
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_reset_pin_b,
   input wire logic boot_mode_pin,
   input wire logic wdt_timeout,
   input wire logic kernel_done,
   output logic kernel_active,
   output logic vector_jump,
   input wire logic user_kernel_req,
   output logic kernel_access_deny,
   input wire logic [31:0] fetch_addr,
   input wire logic [31:0] data_addr,
   output logic fetch_sel_sram,
   output logic data_sel_sram,
   output logic sys_reset,
   output logic gpio_reset,
   output logic dac_reset,
   output logic mirror_sram,
   input wire logic cost_req,
   input wire logic cost_exec_flash,
   input wire logic cost_wide_instr,
   input wire logic cost_has_data,
   input wire logic cost_data_flash,
   input wire logic cost_data_word,
   input wire logic cost_ctrl_flow,
   input wire logic [4:0] cost_count,
   input wire logic [2:0] core_clock_divider,
   output logic cost_valid,
   output logic [7:0] cost_cycles
);

   ////////////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic [2:0] rrc_decode(input logic [31:0] addr);
      case ({addr[31:2], 2'b00})
         rrc_pkg::RRC_ADDR_MIRROR: rrc_decode = rrc_pkg::RRC_SEL_MIRROR;
         rrc_pkg::RRC_ADDR_STATUS: rrc_decode = rrc_pkg::RRC_SEL_STATUS;
         rrc_pkg::RRC_ADDR_CLEAR: rrc_decode = rrc_pkg::RRC_SEL_CLEAR;
         rrc_pkg::RRC_ADDR_KEY_LOW: rrc_decode = rrc_pkg::RRC_SEL_KEY_LOW;
         rrc_pkg::RRC_ADDR_RETAIN: rrc_decode = rrc_pkg::RRC_SEL_RETAIN;
         rrc_pkg::RRC_ADDR_KEY_HIGH: rrc_decode = rrc_pkg::RRC_SEL_KEY_HIGH;
         default: rrc_decode = rrc_pkg::RRC_SEL_NONE;
      endcase
   endfunction

   function automatic logic rrc_in_mirror(input logic [31:0] addr);
      rrc_in_mirror = (addr <= MIRROR_LAST_ADDR);
   endfunction

   // cost of one instruction in core cycles
   function automatic logic [7:0] rrc_cost(input logic exec_flash, input logic wide,
         input logic has_data, input logic data_flash, input logic word,
         input logic ctrl, input logic [4:0] cnt, input logic [2:0] cd);
      logic [7:0] n;
      logic [7:0] total;
      n = (cnt == 5'h00) ? 8'h01 : ((cnt > rrc_pkg::RRC_MAX_XFER) ?
         8'(rrc_pkg::RRC_MAX_XFER) : 8'(cnt));
      total = 8'h00;
      if (!exec_flash) begin
         total = rrc_pkg::RRC_SRAM_FETCH_CYC;
         if (has_data) begin
            total = total + 8'(n * (data_flash ? rrc_pkg::RRC_FLASH_DATA_CYC :
               rrc_pkg::RRC_SRAM_DATA_CYC));
         end
         if (ctrl) begin
            total = total + rrc_pkg::RRC_SRAM_REFILL_CYC;
         end
      end else begin
         // slower divided clocks fit a whole wide fetch into one cycle
         total = (wide && cd == 3'h0) ? rrc_pkg::RRC_FLASH_FETCH_WIDE_CYC :
            rrc_pkg::RRC_FLASH_FETCH_NARROW_CYC;
         if (has_data && data_flash) begin
            total = total + 8'(n * (rrc_pkg::RRC_FLASH_DEAD_CYC + (word ?
               rrc_pkg::RRC_FLASH_WORD_CYC : rrc_pkg::RRC_FLASH_HALF_CYC) +
               rrc_pkg::RRC_FLASH_DEAD_CYC));
         end else if (has_data) begin
            total = total + 8'(n * rrc_pkg::RRC_SRAM_DATA_CYC);
         end
         if (ctrl) begin
            total = total + rrc_pkg::RRC_FLASH_PC_DECODE_CYC +
               rrc_pkg::RRC_FLASH_REFILL_CYC;
         end
      end
      rrc_cost = total;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic ext_meta;
   logic ext_sync;
   logic boot_meta;
   logic boot_sync;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ext_meta <= 1'b1;
         ext_sync <= 1'b1;
         boot_meta <= 1'b0;
         boot_sync <= 1'b0;
      end else begin
         ext_meta <= ext_reset_pin_b;
         ext_sync <= ext_meta;
         boot_meta <= boot_mode_pin;
         boot_sync <= boot_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave, one write and one read at a time

   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic [2:0] wr_sel;
   logic [7:0] wb;
   logic wr_lane;
   logic [2:0] rd_sel;
   logic [7:0] mirror_reg;
   logic [7:0] status;
   logic [7:0] retain;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_sel = rrc_decode(aw_addr_q);
   assign wb = w_data_q[7:0];
   assign wr_lane = wr_fire && w_strb_q[0];
   assign rd_sel = rrc_decode(s_axi_araddr);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == rrc_pkg::RRC_SEL_NONE) ? 2'h3 : 2'h0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= (rd_sel == rrc_pkg::RRC_SEL_NONE) ? 2'h3 : 2'h0;
         case (rd_sel)
            rrc_pkg::RRC_SEL_MIRROR: s_axi_rdata <= {24'h00_0000, mirror_reg};
            rrc_pkg::RRC_SEL_STATUS: s_axi_rdata <= {24'h00_0000, status};
            rrc_pkg::RRC_SEL_RETAIN: s_axi_rdata <= {24'h00_0000, retain};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // reset sources and cause record

   logic ext_evt;
   logic wdt_evt;
   logic sw_evt;
   logic any_evt;
   logic [4:0] hold_cnt;
   logic [4:0] next_hold_cnt;
   logic hold_full;
   logic next_hold_full;

   assign ext_evt = !ext_sync;
   assign wdt_evt = wdt_timeout;
   assign sw_evt = wr_lane && wr_sel == rrc_pkg::RRC_SEL_STATUS && wb[rrc_pkg::RRC_BIT_SW];
   assign any_evt = ext_evt || wdt_evt || sw_evt;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         status <= rrc_pkg::RRC_RST_STATUS;
      end else if (ext_evt) begin
         status <= rrc_pkg::RRC_CAUSE_EXT;
      end else if (wdt_evt) begin
         status <= rrc_pkg::RRC_CAUSE_WDT;
      end else if (sw_evt) begin
         status <= rrc_pkg::RRC_CAUSE_SW;
      end else if (wr_lane && wr_sel == rrc_pkg::RRC_SEL_CLEAR) begin
         status <= status & ~(wb & rrc_pkg::RRC_STATUS_MASK);
      end
   end

   // pin reset restarts the hold every cycle the pin stays low
   always_comb begin
      next_hold_cnt = hold_cnt;
      next_hold_full = hold_full;
      if (any_evt) begin
         next_hold_cnt = rrc_pkg::RRC_RESET_HOLD_CYC;
         next_hold_full = ext_evt;
      end else if (hold_cnt != 5'h00) begin
         next_hold_cnt = hold_cnt - 5'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         hold_cnt <= rrc_pkg::RRC_RESET_HOLD_CYC;
         hold_full <= 1'b1;
         sys_reset <= 1'b1;
         gpio_reset <= 1'b1;
         dac_reset <= 1'b1;
      end else begin
         hold_cnt <= next_hold_cnt;
         hold_full <= next_hold_full;
         sys_reset <= next_hold_cnt != 5'h00;
         gpio_reset <= (next_hold_cnt != 5'h00) &&
            (next_hold_full || !retain[rrc_pkg::RRC_BIT_KEEP_GPIO]);
         dac_reset <= (next_hold_cnt != 5'h00) &&
            (next_hold_full || !retain[rrc_pkg::RRC_BIT_KEEP_DAC]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // retention config behind key sequence

   logic [1:0] key_step;
   logic [7:0] retain_stage;

   // the staged value is masked, so reserved bits always read zero
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         key_step <= 2'h0;
         retain_stage <= rrc_pkg::RRC_RST_RETAIN;
         retain <= rrc_pkg::RRC_RST_RETAIN;
      end else if (any_evt) begin
         key_step <= 2'h0;
      end else if (wr_lane) begin
         case (wr_sel)
            rrc_pkg::RRC_SEL_KEY_LOW: begin
               key_step <= (wb == rrc_pkg::RRC_KEY_FIRST) ? 2'h1 : 2'h0;
            end
            rrc_pkg::RRC_SEL_RETAIN: begin
               if (key_step == 2'h1) begin
                  retain_stage <= wb & rrc_pkg::RRC_RETAIN_MASK;
                  key_step <= 2'h2;
               end else begin
                  key_step <= 2'h0;
               end
            end
            rrc_pkg::RRC_SEL_KEY_HIGH: begin
               if (key_step == 2'h2 && wb == rrc_pkg::RRC_KEY_FINAL) begin
                  retain <= retain_stage;
               end
               key_step <= 2'h0;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // low-memory mirror

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mirror_reg <= rrc_pkg::RRC_RST_MIRROR;
      end else if (any_evt) begin
         mirror_reg <= rrc_pkg::RRC_RST_MIRROR;
      end else if (wr_lane && wr_sel == rrc_pkg::RRC_SEL_MIRROR) begin
         mirror_reg <= {7'h00, wb[rrc_pkg::RRC_BIT_MIRROR]};
      end
   end

   // swapping while fetching from the low region is unsafe; software avoids it
   assign mirror_sram = mirror_reg[rrc_pkg::RRC_BIT_MIRROR];
   assign fetch_sel_sram = mirror_sram && rrc_in_mirror(fetch_addr);
   assign data_sel_sram = mirror_sram && rrc_in_mirror(data_addr);

   ////////////////////////////////////////////////////////////////////////////////
   // boot sequencer

   rrc_pkg::rrc_boot_t boot_state;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         boot_state <= rrc_pkg::RRC_BOOT_HOLD;
         vector_jump <= 1'b0;
      end else begin
         vector_jump <= 1'b0;
         if (any_evt) begin
            boot_state <= rrc_pkg::RRC_BOOT_HOLD;
         end else begin
            case (boot_state)
               rrc_pkg::RRC_BOOT_HOLD: begin
                  if (next_hold_cnt == 5'h00) begin
                     boot_state <= rrc_pkg::RRC_BOOT_KERNEL;
                  end
               end
               rrc_pkg::RRC_BOOT_KERNEL: begin
                  if (kernel_done) begin
                     boot_state <= boot_sync ? rrc_pkg::RRC_BOOT_USER :
                        rrc_pkg::RRC_BOOT_DOWNLOAD;
                     vector_jump <= boot_sync;
                  end
               end
               rrc_pkg::RRC_BOOT_USER: boot_state <= rrc_pkg::RRC_BOOT_USER;
               rrc_pkg::RRC_BOOT_DOWNLOAD: boot_state <= rrc_pkg::RRC_BOOT_DOWNLOAD;
               default: boot_state <= rrc_pkg::RRC_BOOT_HOLD;
            endcase
         end
      end
   end

   assign kernel_active = boot_state == rrc_pkg::RRC_BOOT_KERNEL;
   assign kernel_access_deny = user_kernel_req && !kernel_active;

   ////////////////////////////////////////////////////////////////////////////////
   // access cost

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cost_valid <= 1'b0;
         cost_cycles <= 8'h00;
      end else begin
         cost_valid <= cost_req;
         if (cost_req) begin
            cost_cycles <= rrc_cost(cost_exec_flash, cost_wide_instr, cost_has_data,
               cost_data_flash, cost_data_word, cost_ctrl_flow, cost_count,
               core_clock_divider);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking rrc_cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   a_mirror_on_reset: assert property (any_evt |=> !mirror_sram)
      else $error("mirror not cleared by reset");
   a_mirror_set: assert property (wr_lane && wr_sel == rrc_pkg::RRC_SEL_MIRROR && wb[0]
      && !any_evt |=> mirror_sram)
      else $error("mirror set write ignored");
   a_mirror_back: assert property (wr_lane && wr_sel == rrc_pkg::RRC_SEL_MIRROR && !wb[0]
      |=> !mirror_sram)
      else $error("mirror clear write ignored");
   a_vector_source: assert property (data_addr == 32'h0000_0020 |->
      data_sel_sram == mirror_sram)
      else $error("vector fetch from wrong memory");
   a_kernel_after_hold: assert property ($fell(sys_reset) && !any_evt |-> kernel_active)
      else $error("kernel not entered after reset");
   a_user_vector: assert property (kernel_active && kernel_done && boot_sync && !any_evt
      |=> vector_jump ##1 !kernel_active && !vector_jump)
      else $error("no branch to user vector");
   a_kernel_hidden: assert property (user_kernel_req && $past(boot_state) ==
      rrc_pkg::RRC_BOOT_USER && !$past(any_evt) |-> kernel_access_deny)
      else $error("kernel area reachable");
   a_wdt_cause: assert property (wdt_evt && !ext_evt |=> status == 8'h02 && sys_reset)
      else $error("watchdog cause not recorded");
   a_sw_cause: assert property (sw_evt && !ext_evt && !wdt_evt
      |=> status == 8'h04 ##4 status == 8'h04 || $past(any_evt, 4))
      else $error("software cause lost");
   a_ext_cause: assert property (ext_evt |=> status == 8'h00 && gpio_reset && dac_reset)
      else $error("pin reset not reported");
   a_clear_bits: assert property (wr_lane && wr_sel == rrc_pkg::RRC_SEL_CLEAR && wb == 8'h07
      && !any_evt |=> status == 8'h00)
      else $error("status not cleared");
   a_dac_keep: assert property (wdt_evt && !ext_evt && retain[2] |=> sys_reset && !dac_reset)
      else $error("dac not retained");
   a_gpio_keep: assert property (wdt_evt && !ext_evt && !retain[0] |=> gpio_reset[*4])
      else $error("gpio not reset");
   a_key_commit: assert property (wr_lane && wr_sel == rrc_pkg::RRC_SEL_KEY_HIGH &&
      key_step == 2'h2 && wb == 8'hB1 && !any_evt |=> retain == $past(retain_stage))
      else $error("key sequence did not commit");
   a_cost_sram: assert property (cost_req && !cost_exec_flash && !cost_has_data &&
      !cost_ctrl_flow |=> cost_valid && cost_cycles == 8'h01)
      else $error("sram fetch cost wrong");
   a_cost_flash_ld: assert property (cost_req && cost_exec_flash && cost_wide_instr &&
      core_clock_divider == 3'h0 && cost_has_data && cost_data_flash && cost_data_word &&
      !cost_ctrl_flow && cost_count == 5'h01 |=> cost_cycles == 8'h06)
      else $error("flash load cost wrong");

   c_sw_reset: cover property (sw_evt ##[1:8] kernel_active);
   c_key_commit: cover property (wr_lane && wr_sel == rrc_pkg::RRC_SEL_KEY_HIGH &&
      key_step == 2'h2);
   c_mirror_toggle: cover property (mirror_sram ##[1:50] !mirror_sram);
   c_user_boot: cover property (vector_jump);

endmodule // rrc_reset_remap
`default_nettype wire

//--- src/rrc_pkg.sv
// rrc_pkg: addresses, reset values, codes and cycle costs for the reset/remap block.
// assumes a single 100 MHz core clock domain and AXI4-Lite register access.
package rrc_pkg;
   // register byte addresses
   localparam logic [31:0] RRC_ADDR_MIRROR = 32'hFFFF_0220;
   localparam logic [31:0] RRC_ADDR_STATUS = 32'hFFFF_0230;
   localparam logic [31:0] RRC_ADDR_CLEAR = 32'hFFFF_0234;
   localparam logic [31:0] RRC_ADDR_KEY_LOW = 32'hFFFF_0248;
   localparam logic [31:0] RRC_ADDR_RETAIN = 32'hFFFF_024C;
   localparam logic [31:0] RRC_ADDR_KEY_HIGH = 32'hFFFF_0250;
   // decoder results
   localparam logic [2:0] RRC_SEL_NONE = 3'h0;
   localparam logic [2:0] RRC_SEL_MIRROR = 3'h1;
   localparam logic [2:0] RRC_SEL_STATUS = 3'h2;
   localparam logic [2:0] RRC_SEL_CLEAR = 3'h3;
   localparam logic [2:0] RRC_SEL_KEY_LOW = 3'h4;
   localparam logic [2:0] RRC_SEL_RETAIN = 3'h5;
   localparam logic [2:0] RRC_SEL_KEY_HIGH = 3'h6;
   // reset values and field positions
   localparam logic [7:0] RRC_RST_MIRROR = 8'h00;
   localparam logic [7:0] RRC_RST_STATUS = 8'h01;
   localparam logic [7:0] RRC_RST_RETAIN = 8'h05;
   localparam int RRC_BIT_MIRROR = 0;
   localparam int RRC_BIT_POR = 0;
   localparam int RRC_BIT_WDT = 1;
   localparam int RRC_BIT_SW = 2;
   localparam int RRC_BIT_KEEP_GPIO = 0;
   localparam int RRC_BIT_KEEP_DAC = 2;
   localparam logic [7:0] RRC_CAUSE_EXT = 8'h00;
   localparam logic [7:0] RRC_CAUSE_WDT = 8'h02;
   localparam logic [7:0] RRC_CAUSE_SW = 8'h04;
   localparam logic [7:0] RRC_STATUS_MASK = 8'h07;
   localparam logic [7:0] RRC_RETAIN_MASK = 8'h05;
   localparam logic [7:0] RRC_KEY_FIRST = 8'h76;
   localparam logic [7:0] RRC_KEY_FINAL = 8'hB1;
   // cycle counts
   localparam logic [4:0] RRC_RESET_HOLD_CYC = 5'h04;
   localparam logic [7:0] RRC_SRAM_FETCH_CYC = 8'h01;
   localparam logic [7:0] RRC_SRAM_DATA_CYC = 8'h01;
   localparam logic [7:0] RRC_FLASH_DATA_CYC = 8'h03;
   localparam logic [7:0] RRC_SRAM_REFILL_CYC = 8'h02;
   localparam logic [7:0] RRC_FLASH_FETCH_WIDE_CYC = 8'h02;
   localparam logic [7:0] RRC_FLASH_FETCH_NARROW_CYC = 8'h01;
   localparam logic [7:0] RRC_FLASH_DEAD_CYC = 8'h01;
   localparam logic [7:0] RRC_FLASH_WORD_CYC = 8'h02;
   localparam logic [7:0] RRC_FLASH_HALF_CYC = 8'h01;
   localparam logic [7:0] RRC_FLASH_PC_DECODE_CYC = 8'h01;
   localparam logic [7:0] RRC_FLASH_REFILL_CYC = 8'h04;
   localparam logic [4:0] RRC_MAX_XFER = 5'h10;
   // boot sequencer
   typedef enum logic [1:0] {
      RRC_BOOT_HOLD = 2'b00,
      RRC_BOOT_KERNEL = 2'b01,
      RRC_BOOT_USER = 2'b10,
      RRC_BOOT_DOWNLOAD = 2'b11
   } rrc_boot_t;
endpackage

//--- dv/rrc_core_model.sv
// rrc_core_model: core-side stand-in that runs the hidden boot code and fetches from flash.
// assumes kernel_active from the reset/remap block on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rrc_core_model #(
   parameter int KERNEL_CYC = 6
) (
   input wire logic clock,
   input wire logic kernel_active,
   output logic kernel_done,
   output logic [31:0] fetch_addr
);
   int cnt = 0;
   // code runs above the mirror, so a remap never swaps it away
   assign fetch_addr = 32'h0008_0100;
   always @(posedge clock) begin
      cnt <= kernel_active ? cnt + 1 : 0;
      kernel_done <= kernel_active && (cnt == KERNEL_CYC);
   end
endmodule // rrc_core_model
`default_nettype wire

//--- dv/reset_remap_control_tb.sv
// reset_remap_control_tb: self-checking bench for the reset/remap block.
// assumes rrc_pkg, rrc_reset_remap and rrc_core_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module reset_remap_control_tb;
   logic clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, data_addr, fetch_addr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic ext_reset_pin_b, boot_mode_pin, wdt_timeout, kernel_done, kernel_active, vector_jump;
   logic user_kernel_req, kernel_access_deny, fetch_sel_sram, data_sel_sram, sys_reset;
   logic gpio_reset, dac_reset, mirror_sram, cost_req, cost_valid, cost_exec_flash;
   logic cost_wide_instr, cost_has_data, cost_data_flash, cost_data_word, cost_ctrl_flow;
   logic [4:0] cost_count;
   logic [2:0] core_clock_divider;
   logic [7:0] cost_cycles;
   int bad_count = 0;
   int checks_done = 0;
   int jumps = 0;
   rrc_reset_remap i_rrc_reset_remap (.*);
   rrc_core_model i_rrc_core_model (.*);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) if (vector_jump === 1'b1) jumps <= jumps + 1;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   // address and data offered together, each released once taken
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!(ta && tw)) begin
         @(posedge clock);
         if (s_axi_awready) ta = 1'b1;
         if (s_axi_wready) tw = 1'b1;
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid) @(posedge clock);
      s_axi_bready <= 1'b0;
      chk("bresp", s_axi_bresp, 2'h0);
   endtask
   task automatic rc(input logic [31:0] a, input logic [7:0] e);
      @(posedge clock);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clock); while (!s_axi_rvalid);
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk("rdata", s_axi_rdata, {24'h0, e});
   endtask
   task automatic cost(input logic [5:0] q, input logic [4:0] k, input logic [7:0] e);
      @(posedge clock);
      cost_req <= 1'b1;
      cost_count <= k;
      {cost_exec_flash, cost_wide_instr, cost_has_data, cost_data_flash, cost_data_word,
         cost_ctrl_flow} <= q;
      @(posedge clock);
      cost_req <= 1'b0;
      #1;
      chk("cost_valid", cost_valid, 1);
      chk("cost_cycles", cost_cycles, e);
   endtask
   task automatic keys(input logic [7:0] v);
      wr(rrc_pkg::RRC_ADDR_KEY_LOW, 8'h76);
      wr(rrc_pkg::RRC_ADDR_RETAIN, v);
      wr(rrc_pkg::RRC_ADDR_KEY_HIGH, 8'hB1);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rc(rrc_pkg::RRC_ADDR_STATUS, 8'h01);
      rc(rrc_pkg::RRC_ADDR_MIRROR, 8'h00);
      rc(rrc_pkg::RRC_ADDR_RETAIN, 8'h05);
      rc(32'hFFFF_0240, 8'h00);
      chk("rresp", rr, 2'h3);
      chk("jumps", jumps, 1);
      chk("kern", kernel_active, 0);
      user_kernel_req <= 1'b1;
      #1;
      chk("deny", kernel_access_deny, 1);
   endtask
   task automatic t_mirror;
      wr(rrc_pkg::RRC_ADDR_MIRROR, 8'h01);
      chk("mirror", mirror_sram, 1);
      chk("data_sel", data_sel_sram, 1);
      chk("fetch_sel", fetch_sel_sram, 0);
      wr(rrc_pkg::RRC_ADDR_MIRROR, 8'h00);
      chk("mirror", mirror_sram, 0);
      chk("data_sel", data_sel_sram, 0);
      wr(rrc_pkg::RRC_ADDR_MIRROR, 8'h01);
   endtask
   task automatic t_sw;
      keys(8'h00);
      wr(rrc_pkg::RRC_ADDR_RETAIN, 8'h05);
      rc(rrc_pkg::RRC_ADDR_RETAIN, 8'h00);
      wr(rrc_pkg::RRC_ADDR_STATUS, 8'h04);
      repeat (2) @(posedge clock);
      chk("gpio_rst", gpio_reset, 1);
      chk("dac_rst", dac_reset, 1);
      repeat (30) @(posedge clock);
      rc(rrc_pkg::RRC_ADDR_STATUS, 8'h04);
      rc(rrc_pkg::RRC_ADDR_MIRROR, 8'h00);
   endtask
   task automatic t_ext;
      ext_reset_pin_b <= 1'b0;
      boot_mode_pin <= 1'b0;
      repeat (6) @(posedge clock);
      chk("gpio_rst", gpio_reset, 1);
      chk("dac_rst", dac_reset, 1);
      ext_reset_pin_b <= 1'b1;
      repeat (30) @(posedge clock);
      rc(rrc_pkg::RRC_ADDR_STATUS, 8'h00);
      chk("jumps", jumps, 2);
      boot_mode_pin <= 1'b1;
   endtask
   task automatic t_wdt;
      keys(8'h05);
      wdt_timeout <= 1'b1;
      @(posedge clock);
      wdt_timeout <= 1'b0;
      @(posedge clock);
      chk("sys_rst", sys_reset, 1);
      chk("gpio_rst", gpio_reset, 0);
      chk("dac_rst", dac_reset, 0);
      repeat (30) @(posedge clock);
      rc(rrc_pkg::RRC_ADDR_STATUS, 8'h02);
      chk("jumps", jumps, 3);
      wr(rrc_pkg::RRC_ADDR_CLEAR, 8'h07);
      rc(rrc_pkg::RRC_ADDR_STATUS, 8'h00);
   endtask
   initial begin
      {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, wdt_timeout, user_kernel_req, cost_req} = '0;
      {cost_exec_flash, cost_wide_instr, cost_has_data, cost_data_flash} = '0;
      {cost_data_word, cost_ctrl_flow, core_clock_divider} = '0;
      {ext_reset_pin_b, boot_mode_pin, s_axi_wstrb, cost_count} = {6'h3F, 5'h01};
      data_addr = 32'h0000_0020;
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      repeat (30) @(posedge clock);
      t_regs;
      t_mirror;
      t_sw;
      t_ext;
      t_wdt;
      cost(6'b001100, 5'h01, 8'h04);
      cost(6'b000001, 5'h01, 8'h03);
      cost(6'b111110, 5'h01, 8'h06);
      cost(6'b101100, 5'h01, 8'h04);
      cost(6'b110001, 5'h01, 8'h07);
      cost(6'b101110, 5'h10, 8'h41);
      wrap_up;
   end
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      wrap_up;
   end
endmodule // reset_remap_control_tb
`default_nettype wire
